/* File: asps_params.svh */
// Character codes, field sizes and counts of the serial parameter slave.
`ifndef ASPS_PARAMS_SVH
`define ASPS_PARAMS_SVH

// ----------------------------------------------------------------------
// Control characters
// ----------------------------------------------------------------------
`define ASPS_EOT      8'h04
`define ASPS_ENQ      8'h05
`define ASPS_STX      8'h02
`define ASPS_ETX      8'h03
`define ASPS_ACK      8'h06
`define ASPS_BS       8'h08
`define ASPS_NAK      8'h15

// ----------------------------------------------------------------------
// Printable characters and checksum floor
// ----------------------------------------------------------------------
`define ASPS_PLUS     8'h2b
`define ASPS_MINUS    8'h2d
`define ASPS_DIG_LO   8'h30
`define ASPS_DIG_HI   8'h39
`define ASPS_BCC_MIN  8'h20

// ----------------------------------------------------------------------
// Field sizes and counts
// ----------------------------------------------------------------------
`define ASPS_ADDR_LEN 3'h4
`define ASPS_ID_LEN   3'h4
`define ASPS_MAX_DIG  3'h5
`define ASPS_RPL_LEN  4'hc
`define ASPS_RPL_LAST 4'h1
`define ASPS_BCD_TOP  4'h9

`endif

/* File: asps_pkg.sv */
// Types shared by the serial parameter slave.
package asps_pkg;

  // ----------------------------------------------------------------------
  // Protocol engine states, one-hot.
  // ----------------------------------------------------------------------
  typedef enum logic [10:0] {
    ASPS_S_IDLE  = 11'h001,
    ASPS_S_ADDR  = 11'h002,
    ASPS_S_SEL   = 11'h004,
    ASPS_S_CPAR  = 11'h008,
    ASPS_S_CDATA = 11'h010,
    ASPS_S_CBCC  = 11'h020,
    ASPS_S_RPAR  = 11'h040,
    ASPS_S_WEXEC = 11'h080,
    ASPS_S_REXEC = 11'h100,
    ASPS_S_TX    = 11'h200,
    ASPS_S_NAV   = 11'h400
  } asps_state_t;

endpackage

/* File: asps_slave.sv */
// Character-level protocol engine answering a host on an ASCII serial line.
`timescale 1ns/1ps
`include "asps_params.svh"

// What this block does
// - Address zero is accepted as the broadcast address.
// - Broadcast commands execute with no reply.
// - Sign plus five digits means high resolution.
// - Wide integers take five digits, no sign.
// - Five unsigned digits accepted for any parameter.
// - Good applied write answers with ACK.
// - Malformed, overlong or bad-checksum write answers NAK.
// - Out-of-limit value rejected with NAK.
// - Read reply: STX id five data ETX BCC.
// - Reply data starts with sign, then magnitude.
// - NAK after reply repeats same parameter.
// - ACK after reply moves to next parameter.
// - BS after reply moves to previous parameter.
// - Unknown parameter answered with EOT on read, NAK on write.
// - Checksum XORs id through ETX inclusive.
// - Checksum below 32 gets 32 added.
// - Control characters use the fixed hex codes.
// - Address digits each sent twice after EOT.
// - Parameter id is menu then parameter digits.
// - EOT abandons message and restarts parsing.
module asps_slave
  import asps_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Own station address, two BCD digits.
  input  wire logic [7:0]  station_addr_i,
  // Received character stream.
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_char_i,
  output logic             rx_ready_o,
  // Transmitted character stream.
  output logic             tx_valid_o,
  output logic [7:0]       tx_char_o,
  input  wire logic        tx_ready_i,
  // Parameter store: selected id and its properties.
  output logic [15:0]      par_id_o,
  input  wire logic        par_exists_i,
  input  wire logic        par_wide_i,
  input  wire logic        par_hires_i,
  input  wire logic        par_in_range_i,
  // Parameter store: write request.
  output logic             par_wr_o,
  output logic             par_wr_neg_o,
  output logic             par_wr_hires_o,
  output logic [19:0]      par_wr_bcd_o,
  // Parameter store: read data.
  input  wire logic        par_rd_neg_i,
  input  wire logic [15:0] par_rd_bcd_i
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // True for an ASCII decimal digit.
  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= `ASPS_DIG_LO) && (c <= `ASPS_DIG_HI);
  endfunction

  // Lifts a raw XOR result out of the control-code range.
  function automatic logic [7:0] bcc_fix(input logic [7:0] x);
    bcc_fix = (x < `ASPS_BCC_MIN) ? (x + `ASPS_BCC_MIN) : x;
  endfunction

  // Steps a four-digit BCD id up or down by one, wrapping at the ends.
  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic up);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (c) begin
        if (up) begin
          if (r[4*k +: 4] == `ASPS_BCD_TOP) begin
            r[4*k +: 4] = 4'h0;
          end else begin
            r[4*k +: 4] = r[4*k +: 4] + 4'h1;
            c = 1'b0;
          end
        end else begin
          if (r[4*k +: 4] == 4'h0) begin
            r[4*k +: 4] = `ASPS_BCD_TOP;
          end else begin
            r[4*k +: 4] = r[4*k +: 4] - 4'h1;
            c = 1'b0;
          end
        end
      end
    end
    bcd_step = r;
  endfunction

  // ----------------------------------------------------------------------
  // State and datapath registers
  // ----------------------------------------------------------------------
  asps_state_t state_q;            // Protocol engine state.
  logic [2:0]  cnt_q;              // Position within address or id field.
  logic [7:0]  addr_q [0:2];       // First three address characters.
  logic        bcast_q;            // Message went to the broadcast address.
  logic        err_q;              // Format fault seen in this message.
  logic [7:0]  acc_q;              // Running checksum of received text.
  logic [15:0] id_q;               // Selected parameter, four BCD digits.
  logic        sign_q;             // Data field opened with a sign.
  logic        neg_q;              // That sign was a minus.
  logic [2:0]  ndig_q;             // Data digits received.
  logic [19:0] bcd_q;              // Data digits, last one lowest.
  logic        hires_q;            // Write asks for high resolution.
  logic        wr_q;               // One-cycle write strobe.
  logic        nav_q;              // Await navigation once sending ends.
  logic [3:0]  left_q;             // Characters still to send.
  logic [7:0]  tx_buf_q [0:11];    // Outgoing characters, head first.

  // ----------------------------------------------------------------------
  // Combinational decisions
  // ----------------------------------------------------------------------
  logic        rx_take;            // A character is taken this cycle.
  logic        addr_fmt;           // Address characters are doubled digits.
  logic        addr_mine;          // Address equals the station address.
  logic        addr_zero;          // Address is the broadcast address.
  logic        wr_bad;             // Write must be refused.
  logic        load_long;          // Load a full read reply.
  logic        load_one;           // Load a single answer character.
  logic [7:0]  one_char;           // That single character.
  logic        tx_shift;           // Head character accepted downstream.
  logic [7:0]  reply_w [0:11];     // Read reply as it would be sent.

  // Receive is held off while a decision or a reply is in progress, so
  // the host cannot overrun the single-character datapath.
  assign rx_ready_o = (state_q != ASPS_S_WEXEC) && (state_q != ASPS_S_REXEC) &&
                      (state_q != ASPS_S_TX);
  assign rx_take    = rx_valid_i && rx_ready_o;
  assign tx_shift   = (state_q == ASPS_S_TX) && tx_ready_i;

  // The fourth address character is checked as it arrives.
  assign addr_fmt  = is_dig(addr_q[0]) && (addr_q[0] == addr_q[1]) &&
                     is_dig(addr_q[2]) && (addr_q[2] == rx_char_i);
  assign addr_mine = ({addr_q[0][3:0], addr_q[2][3:0]} == station_addr_i);
  assign addr_zero = (addr_q[0][3:0] == 4'h0) && (rx_char_i[3:0] == 4'h0);

  // A write fails on a format fault, an unknown target, a wrong field
  // shape for the target, or a value outside the target's limits.
  assign wr_bad = err_q || !par_exists_i ||
                  (par_wide_i && (sign_q || (ndig_q != `ASPS_MAX_DIG))) ||
                  (hires_q && !par_hires_i) ||
                  !par_in_range_i;

  assign load_long = (state_q == ASPS_S_REXEC) && par_exists_i;
  assign load_one  = ((state_q == ASPS_S_REXEC) && !par_exists_i) ||
                     ((state_q == ASPS_S_WEXEC) && !bcast_q);
  // Unknown parameters get EOT; writes get ACK or NAK.
  assign one_char  = (state_q == ASPS_S_REXEC) ? `ASPS_EOT :
                     (wr_bad ? `ASPS_NAK : `ASPS_ACK);

  // Builds the read reply with its checksum over id, data and ETX.
  always_comb begin
    logic [7:0] x;
    x = 8'h00;
    reply_w[0]  = `ASPS_STX;
    for (int k = 0; k < 4; k++) begin
      reply_w[1 + k] = `ASPS_DIG_LO | {4'h0, id_q[4*(3-k) +: 4]};
      reply_w[6 + k] = `ASPS_DIG_LO | {4'h0, par_rd_bcd_i[4*(3-k) +: 4]};
    end
    reply_w[5]  = par_rd_neg_i ? `ASPS_MINUS : `ASPS_PLUS;
    reply_w[10] = `ASPS_ETX;
    for (int k = 1; k < 11; k++) begin
      x = x ^ reply_w[k];
    end
    reply_w[11] = bcc_fix(x);
  end

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------

  // Parses both message kinds. EOT is honoured from every receiving
  // state, so a line glitch costs one message rather than the link.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= ASPS_S_IDLE;
      cnt_q   <= 3'h0;
      bcast_q <= 1'b0;
      err_q   <= 1'b0;
      nav_q   <= 1'b0;
    end else if (rx_take && (rx_char_i == `ASPS_EOT)) begin
      state_q <= ASPS_S_ADDR;
      cnt_q   <= 3'h0;
    end else begin
      case (state_q)
        ASPS_S_IDLE: begin
          state_q <= ASPS_S_IDLE;
        end
        ASPS_S_ADDR: begin
          if (rx_take) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `ASPS_ADDR_LEN - 3'h1) begin
              // Foreign or garbled addresses are dropped silently.
              bcast_q <= addr_zero;
              state_q <= (addr_fmt && (addr_mine || addr_zero)) ?
                         ASPS_S_SEL : ASPS_S_IDLE;
            end
          end
        end
        ASPS_S_SEL: begin
          if (rx_take) begin
            err_q <= 1'b0;
            cnt_q <= 3'h1;
            if (rx_char_i == `ASPS_STX) begin
              state_q <= ASPS_S_CPAR;
              cnt_q   <= 3'h0;
            end else if (is_dig(rx_char_i)) begin
              state_q <= ASPS_S_RPAR;
            end else begin
              state_q <= ASPS_S_IDLE;
            end
          end
        end
        ASPS_S_CPAR: begin
          if (rx_take) begin
            err_q <= err_q || !is_dig(rx_char_i);
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `ASPS_ID_LEN - 3'h1) begin
              state_q <= ASPS_S_CDATA;
            end
          end
        end
        ASPS_S_CDATA: begin
          if (rx_take) begin
            if (rx_char_i == `ASPS_ETX) begin
              err_q   <= err_q || (ndig_q == 3'h0);
              state_q <= ASPS_S_CBCC;
            end else if (((rx_char_i == `ASPS_PLUS) || (rx_char_i == `ASPS_MINUS)) &&
                         !sign_q && (ndig_q == 3'h0)) begin
              err_q <= err_q;
            end else if (!is_dig(rx_char_i) || (ndig_q == `ASPS_MAX_DIG)) begin
              err_q <= 1'b1;
            end
          end
        end
        ASPS_S_CBCC: begin
          if (rx_take) begin
            err_q   <= err_q || (rx_char_i != bcc_fix(acc_q));
            state_q <= ASPS_S_WEXEC;
          end
        end
        ASPS_S_RPAR: begin
          if (rx_take) begin
            if (cnt_q != `ASPS_ID_LEN) begin
              err_q <= err_q || !is_dig(rx_char_i);
              cnt_q <= cnt_q + 3'h1;
            end else if ((rx_char_i == `ASPS_ENQ) && !err_q) begin
              state_q <= ASPS_S_REXEC;
            end else begin
              // A garbled request is refused like a garbled command.
              err_q   <= 1'b1;
              state_q <= ASPS_S_WEXEC;
            end
          end
        end
        ASPS_S_WEXEC: begin
          nav_q   <= 1'b0;
          state_q <= bcast_q ? ASPS_S_IDLE : ASPS_S_TX;
        end
        ASPS_S_REXEC: begin
          nav_q   <= par_exists_i;
          state_q <= ASPS_S_TX;
        end
        ASPS_S_TX: begin
          if (tx_ready_i && (left_q == `ASPS_RPL_LAST)) begin
            state_q <= nav_q ? ASPS_S_NAV : ASPS_S_IDLE;
          end
        end
        ASPS_S_NAV: begin
          if (rx_take && ((rx_char_i == `ASPS_NAK) || (rx_char_i == `ASPS_ACK) ||
                          (rx_char_i == `ASPS_BS))) begin
            state_q <= ASPS_S_REXEC;
          end
        end
        default: begin
          state_q <= ASPS_S_IDLE;
        end
      endcase
    end
  end

  // Captures the first three address characters.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      addr_q[0] <= 8'h00;
      addr_q[1] <= 8'h00;
      addr_q[2] <= 8'h00;
    end else if (rx_take && (state_q == ASPS_S_ADDR) && (cnt_q != 3'h3)) begin
      addr_q[cnt_q[1:0]] <= rx_char_i;
    end
  end

  // Shifts in id digits and steps the id on navigation characters.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      id_q <= 16'h0000;
    end else if (rx_take && (state_q == ASPS_S_NAV)) begin
      if (rx_char_i == `ASPS_ACK) begin
        id_q <= bcd_step(id_q, 1'b1);
      end else if (rx_char_i == `ASPS_BS) begin
        id_q <= bcd_step(id_q, 1'b0);
      end
    end else if (rx_take && is_dig(rx_char_i) &&
                 ((state_q == ASPS_S_SEL) || (state_q == ASPS_S_CPAR) ||
                  ((state_q == ASPS_S_RPAR) && (cnt_q != `ASPS_ID_LEN)))) begin
      id_q <= {id_q[11:0], rx_char_i[3:0]};
    end
  end

  // Running checksum of command text from the id up to ETX.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_q <= 8'h00;
    end else if (rx_take && (state_q == ASPS_S_SEL)) begin
      acc_q <= 8'h00;
    end else if (rx_take && ((state_q == ASPS_S_CPAR) || (state_q == ASPS_S_CDATA))) begin
      acc_q <= acc_q ^ rx_char_i;
    end
  end

  // Collects the data field: optional leading sign, then digits.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sign_q  <= 1'b0;
      neg_q   <= 1'b0;
      ndig_q  <= 3'h0;
      bcd_q   <= 20'h00000;
      hires_q <= 1'b0;
    end else if (rx_take && (state_q == ASPS_S_SEL)) begin
      sign_q  <= 1'b0;
      neg_q   <= 1'b0;
      ndig_q  <= 3'h0;
      bcd_q   <= 20'h00000;
      hires_q <= 1'b0;
    end else if (rx_take && (state_q == ASPS_S_CDATA)) begin
      if (rx_char_i == `ASPS_ETX) begin
        hires_q <= sign_q && (ndig_q == `ASPS_MAX_DIG);
      end else if (((rx_char_i == `ASPS_PLUS) || (rx_char_i == `ASPS_MINUS)) &&
                   !sign_q && (ndig_q == 3'h0)) begin
        sign_q <= 1'b1;
        neg_q  <= (rx_char_i == `ASPS_MINUS);
      end else if (is_dig(rx_char_i) && (ndig_q != `ASPS_MAX_DIG)) begin
        bcd_q  <= {bcd_q[15:0], rx_char_i[3:0]};
        ndig_q <= ndig_q + 3'h1;
      end
    end
  end

  // Write strobe, one cycle after an accepted command is decided.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= (state_q == ASPS_S_WEXEC) && !wr_bad;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------

  // Number of characters left; the head is always tx_buf_q[0].
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      left_q <= 4'h0;
    end else if (load_long) begin
      left_q <= `ASPS_RPL_LEN;
    end else if (load_one) begin
      left_q <= `ASPS_RPL_LAST;
    end else if (tx_shift) begin
      left_q <= left_q - 4'h1;
    end
  end

  // Each slot loads from the reply image or the single answer, or takes its neighbour's value; the last slot takes zero.
  for (genvar i = 0; i < 12; i++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
        tx_buf_q[i] <= 8'h00;
      end else if (load_long) begin
        tx_buf_q[i] <= reply_w[i];
      end else if (load_one) begin
        tx_buf_q[i] <= (i == 0) ? one_char : 8'h00;
      end else if (tx_shift) begin
        tx_buf_q[i] <= (i == 11) ? 8'h00 : tx_buf_q[(i + 1) % 12];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign tx_valid_o     = (state_q == ASPS_S_TX);
  assign tx_char_o      = tx_buf_q[0];
  assign par_id_o       = id_q;
  assign par_wr_o       = wr_q;
  assign par_wr_neg_o   = neg_q;
  assign par_wr_hires_o = hires_q;
  assign par_wr_bcd_o   = bcd_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_bcast_silent: assert property (
    (state_q == ASPS_S_WEXEC) && bcast_q |=> !tx_valid_o && (state_q == ASPS_S_IDLE))
    else $error("broadcast command produced a reply");
  chk_write_ack: assert property (
    (state_q == ASPS_S_WEXEC) && !bcast_q && !wr_bad |=>
      wr_q && tx_valid_o && (tx_char_o == `ASPS_ACK))
    else $error("accepted write not strobed and acknowledged");
  chk_write_nak: assert property (
    (state_q == ASPS_S_WEXEC) && !bcast_q && err_q |=> tx_char_o == `ASPS_NAK)
    else $error("faulty message not answered with NAK");
  chk_range_nak: assert property (
    (state_q == ASPS_S_WEXEC) && !par_in_range_i |=> !wr_q)
    else $error("out-of-limit value was written");
  chk_reply_frame: assert property (
    load_long |=> (tx_char_o == `ASPS_STX) && (left_q == `ASPS_RPL_LEN) &&
                  (tx_buf_q[10] == `ASPS_ETX))
    else $error("read reply frame malformed");
  chk_reply_sign: assert property (
    load_long |=> (tx_buf_q[5] == `ASPS_PLUS) || (tx_buf_q[5] == `ASPS_MINUS))
    else $error("reply data lacks a sign");
  chk_reply_bcc: assert property (
    load_long |=> tx_buf_q[11] >= `ASPS_BCC_MIN)
    else $error("reply checksum in control range");
  chk_unknown_eot: assert property (
    (state_q == ASPS_S_REXEC) && !par_exists_i |=>
      (tx_char_o == `ASPS_EOT) && (left_q == `ASPS_RPL_LAST))
    else $error("unknown parameter not answered with EOT");
  chk_eot_restart: assert property (
    rx_take && (rx_char_i == `ASPS_EOT) |=> (state_q == ASPS_S_ADDR) && (cnt_q == 3'h0))
    else $error("EOT did not restart parsing");
  chk_nav_next: assert property (
    rx_take && (state_q == ASPS_S_NAV) && (rx_char_i == `ASPS_ACK) |=>
      (id_q == bcd_step($past(id_q), 1'b1)) && (state_q == ASPS_S_REXEC) &&
      (load_long || !par_exists_i))
    else $error("ACK did not advance to the next parameter");

  cov_write_ack: cover property (wr_q ##1 (tx_char_o == `ASPS_ACK));
  cov_read_reply: cover property (load_long ##[1:40] (state_q == ASPS_S_NAV));
  cov_nav_back: cover property (rx_take && (state_q == ASPS_S_NAV) &&
                                (rx_char_i == `ASPS_BS));
  cov_bcast_write: cover property ((state_q == ASPS_S_WEXEC) && bcast_q && !wr_bad);

endmodule

/* File: asps_store_model.sv */
// Parameter store model answering the lookups of the serial slave.
`timescale 1ns/1ps
module asps_store_model (
  // Selected parameter and value offered for writing.
  input  wire logic [15:0] par_id_i,
  input  wire logic [19:0] wr_bcd_i,
  // Answers to the slave, settled in the same cycle.
  output logic             exists_o,
  output logic             wide_o,
  output logic             hires_o,
  output logic             in_range_o,
  output logic             rd_neg_o,
  output logic [15:0]      rd_bcd_o
);
  // Number 17.23 is absent, so an unknown lookup can be provoked.
  assign exists_o   = (par_id_i != 16'h1723);
  assign wide_o     = (par_id_i == 16'h1314);
  assign hires_o    = (par_id_i == 16'h0117);
  // All nines stands for a value beyond every limit.
  assign in_range_o = (wr_bcd_i != 20'h99999);
  // Odd numbers read negative and echo their own id, so replies are predictable.
  assign rd_neg_o   = par_id_i[0];
  assign rd_bcd_o   = par_id_i;
endmodule

/* File: ansi_serial_parameter_slave_tb.sv */
// Self-checking testbench of the serial parameter slave.
`timescale 1ns/1ps
module ansi_serial_parameter_slave_tb;
  logic clk_i = 0, nrst_i = 0, rx_valid_i = 0, tx_ready_i = 1, slow = 0;
  logic [7:0]  rx_char_i = 8'h00;
  logic        rx_ready_o, tx_valid_o, par_wr_o, par_wr_neg_o, par_wr_hires_o;
  logic [7:0]  tx_char_o;
  logic [15:0] par_id_o, par_rd_bcd_i;
  logic [19:0] par_wr_bcd_o;
  logic        ex, wd, hr, ir, rn;
  logic [21:0] wr = 22'h000000;
  int          nwr = 0, miscompares = 0, n_compared = 0;
  string       got = "";
  asps_slave DUT (.clk_i(clk_i), .nrst_i(nrst_i), .station_addr_i(8'h14),
    .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i), .rx_ready_o(rx_ready_o),
    .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o), .tx_ready_i(tx_ready_i),
    .par_id_o(par_id_o), .par_exists_i(ex), .par_wide_i(wd), .par_hires_i(hr),
    .par_in_range_i(ir), .par_wr_o(par_wr_o), .par_wr_neg_o(par_wr_neg_o),
    .par_wr_hires_o(par_wr_hires_o), .par_wr_bcd_o(par_wr_bcd_o),
    .par_rd_neg_i(rn), .par_rd_bcd_i(par_rd_bcd_i));
  asps_store_model store (.par_id_i(par_id_o), .wr_bcd_i(par_wr_bcd_o), .exists_o(ex),
    .wide_o(wd), .hires_o(hr), .in_range_o(ir), .rd_neg_o(rn), .rd_bcd_o(par_rd_bcd_i));
  initial forever #10 clk_i = ~clk_i;
  // Capture answers and writes; a slow host stalls every other cycle.
  always @(posedge clk_i) begin
    tx_ready_i <= slow ? ~tx_ready_i : 1'b1;
    if (tx_valid_o === 1'b1 && tx_ready_i) got = {got, string'(tx_char_o)};
    if (par_wr_o === 1'b1) begin
      nwr++;
      wr = {par_wr_neg_o, par_wr_hires_o, par_wr_bcd_o};
    end
  end
  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_s(string g, string e);
    n_compared++;
    if (g != e) begin miscompares++; $display("MISMATCH %0t answer length %0d", $time, g.len()); end
  endtask
  task automatic cmp_v(logic [21:0] g, logic [21:0] e);
    n_compared++;
    if (g !== e) begin miscompares++; $display("MISMATCH %0t got %h want %h", $time, g, e); end
  endtask
  // Checksum over the text, lifted clear of the control codes.
  function automatic string bcc(string s);
    logic [7:0] x = 8'h00;
    foreach (s[i]) x ^= s[i];
    if (x < 8'h20) x += 8'h20;
    return string'(x);
  endfunction
  function automatic string wmsg(string a, string b);
    return {"\004", a, "\002", b, "\003", bcc({b, "\003"})};
  endfunction
  function automatic string rep(string id, string sg);
    return {"\002", id, sg, id, "\003", bcc({id, sg, id, "\003"})};
  endfunction
  // Offer each character and hold it until the slave takes it.
  task automatic send(string s);
    logic r;
    foreach (s[i]) begin
      rx_valid_i <= 1'b1;
      rx_char_i  <= s[i];
      do begin @(negedge clk_i); r = rx_ready_o; @(posedge clk_i); end while (r !== 1'b1);
    end
    rx_valid_i <= 1'b0;
  endtask
  task automatic expect_tx(string e);
    for (int i = 0; i < 80 && got.len() < e.len(); i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    cmp_s(got, e);
    got = "";
  endtask
  task automatic t_writes;
    send(wmsg("1144", "0117+04765")); expect_tx("\006");
    cmp_v(wr, {2'b01, 20'h04765});
    send(wmsg("1144", "131413147")); expect_tx("\006");
    cmp_v(wr, {2'b00, 20'h13147});
    send(wmsg("1144", "1314+1314")); expect_tx("\025");
  endtask
  task automatic t_faults;
    send("\0041144\0020117-0476\003x"); expect_tx("\025");
    send(wmsg("1144", "0117123456")); expect_tx("\025");
    send(wmsg("1144", "011899999")); expect_tx("\025");
    send("\0041144011x\005"); expect_tx("\025");
    send({"\0041144\00201", wmsg("1144", "0120-0012")}); expect_tx("\006");
    cmp_v(wr, {2'b10, 20'h00012});
    cmp_v(22'(nwr), 22'd3);
  endtask
  task automatic t_read;
    slow = 1;
    send("\00411440117\005"); expect_tx(rep("0117", "-"));
    send("\006"); expect_tx(rep("0118", "+"));
    send("\010"); expect_tx(rep("0117", "-"));
    send("\025"); expect_tx(rep("0117", "-"));
    slow = 0;
    send("\00411441723\005"); expect_tx("\004");
  endtask
  task automatic t_silent;
    send(wmsg("0000", "0120+0005")); expect_tx("");
    cmp_v(wr, {2'b00, 20'h00005});
    send(wmsg("2222", "0120+00007")); expect_tx("");
    send("\00422220117\005"); expect_tx("");
    cmp_v(22'(nwr), 22'd4);
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_writes();
    t_faults();
    t_read();
    t_silent();
    conclude();
  end
endmodule
